// ==== design/uaf_defs.svh ====
// constants of the address-filtering serial port: offsets, fields, resets, timing
//
// What this block does
// - with filter mode set, frames without address information never reach the receive fifo
// - the transmitter ignores the filter mode bit entirely
// - for 5 to 8 data bits the first stop bit marks the frame type
// - for nine data bits the received ninth bit marks the frame type
// - frame type one means address frame, zero means data frame
// - an accepted address frame is stored and raises receive complete like any frame
// - the data location writes the transmit buffer and reads the receive buffer
// - unused upper bits are ignored on transmit and read back as zero
// - a data write while the transmit buffer is full is ignored
// - an enabled transmitter moves the buffered character into an empty shifter and sends it
// - the receive buffer is a two-entry fifo advanced by each data location read
// - receive complete tracks unread data; disabling the receiver flushes the fifo
`ifndef UAF_DEFS_SVH
`define UAF_DEFS_SVH

// ****************************************************************
// register offsets (byte addresses on the apb bus)
// ****************************************************************
`define UAF_OFS_DATA     8'h00
`define UAF_OFS_STAT_A   8'h04
`define UAF_OFS_CTRL_B   8'h08
`define UAF_OFS_CTRL_C   8'h0C

// ****************************************************************
// field positions
// ****************************************************************
`define UAF_A_RX_DONE    7
`define UAF_A_TX_DONE    6
`define UAF_A_TX_FREE    5
`define UAF_A_FE         4
`define UAF_A_DOR        3
`define UAF_A_PE         2
`define UAF_A_U2X        1
`define UAF_A_FILT       0
`define UAF_B_RXEN       4
`define UAF_B_TXEN       3
`define UAF_B_SIZE2      2
`define UAF_B_RX9        1
`define UAF_B_TX9        0
`define UAF_C_STOP       3
`define UAF_C_SIZE_HI    2
`define UAF_C_SIZE_LO    1

// ****************************************************************
// reset values and codes
// ****************************************************************
`define UAF_RST_SIZE10   2'h3
`define UAF_SIZE_NINE    3'h7

// ****************************************************************
// timing: one serial bit at 25 MHz
// ****************************************************************
`define UAF_CLK_NS       40
`define UAF_BIT_NS       640
`define UAF_BIT_CYC      (`UAF_BIT_NS / `UAF_CLK_NS)

`endif

// ==== design/uaf_pkg.sv ====
// types shared by the address-filtering serial port
package uaf_pkg;

  // frame handed over by the bit recovery logic, one-cycle valid
  typedef struct packed {
    logic       valid;
    logic [8:0] data;
    logic       stop1;
    logic       parity_err;
  } uaf_rx_frame_s;

  // one receive fifo entry with its status
  typedef struct packed {
    logic       fe;
    logic       pe;
    logic [8:0] data;
  } uaf_rx_entry_s;

  typedef enum logic [0:0] {
    UAF_TX_IDLE  = 1'b0,
    UAF_TX_SHIFT = 1'b1
  } uaf_tx_state_e;

  typedef logic [2:0] uaf_size_t;

endpackage

// ==== design/uaf_top.sv ====
// address-filtering receive fifo, transmit buffer and shifter behind an apb slave
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "uaf_defs.svh"

module uaf_top import uaf_pkg::*; #(
  parameter int BIT_CYCLES = `UAF_BIT_CYC
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // from bit recovery logic, same clock
  input  wire uaf_rx_frame_s rx_frame,
  // to bit recovery logic
  output logic               rx_enable,
  output uaf_size_t          char_size,
  // serial transmit pin
  output logic               txd,
  output logic               txd_oe
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // valid-bit mask for a size code; codes 4..6 are treated as 8 bits
  function automatic logic [8:0] size_mask(input uaf_size_t s);
    case (s)
      3'h0:    size_mask = 9'h01F;
      3'h1:    size_mask = 9'h03F;
      3'h2:    size_mask = 9'h07F;
      3'h7:    size_mask = 9'h1FF;
      default: size_mask = 9'h0FF;
    endcase
  endfunction

  function automatic logic [3:0] size_bits(input uaf_size_t s);
    case (s)
      3'h0:    size_bits = 4'h5;
      3'h1:    size_bits = 4'h6;
      3'h2:    size_bits = 4'h7;
      3'h7:    size_bits = 4'h9;
      default: size_bits = 4'h8;
    endcase
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic          filt_q, filt_d;
  logic          u2x_q, u2x_d;
  logic          rx_en_q, rx_en_d;
  logic          tx_en_q, tx_en_d;
  logic          tx9_q, tx9_d;
  logic          stop2_q, stop2_d;
  uaf_size_t     size_q, size_d;
  logic          tx_done_q, tx_done_d;
  logic          dor_q, dor_d;
  uaf_rx_entry_s ent_q [2];
  uaf_rx_entry_s ent_d [2];
  logic [1:0]    cnt_q, cnt_d;
  logic [8:0]    txbuf_q, txbuf_d;
  logic          txfull_q, txfull_d;
  logic          tx_on_q, tx_on_d;
  uaf_tx_state_e tx_st_q, tx_st_d;
  logic [12:0]   sh_q, sh_d;
  logic [3:0]    left_q, left_d;
  logic [15:0]   baud_q, baud_d;
  logic [31:0]   rdata_q, rdata_d;

  // decoded access terms
  logic          access, wr, rd_data, wr_data, mapped;
  logic          ftype, keep, push, load, done;
  logic [1:0]    cnt_n;
  logic [8:0]    mask;
  logic [31:0]   rsel;
  uaf_rx_entry_s head, newent;

  // ****************************************************************
  // apb decode; zero wait states, read data sampled in the setup cycle
  // ****************************************************************
  always_comb begin
    access  = psel && penable;
    wr      = access && pwrite;
    mapped  = (paddr == `UAF_OFS_DATA) || (paddr == `UAF_OFS_STAT_A) ||
              (paddr == `UAF_OFS_CTRL_B) || (paddr == `UAF_OFS_CTRL_C);
    rd_data = access && !pwrite && (paddr == `UAF_OFS_DATA);
    wr_data = wr && (paddr == `UAF_OFS_DATA);
    head    = ent_q[0];
    mask    = size_mask(size_q);
  end

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = rdata_q;

  // ****************************************************************
  // receive path: type bit, filter, two-entry fifo
  // ****************************************************************
  always_comb begin
    // nine-bit frames carry the type in bit 8, shorter ones in the first stop bit
    ftype  = (size_q == `UAF_SIZE_NINE) ? rx_frame.data[8] : rx_frame.stop1;
    keep   = !filt_q || ftype;
    push   = rx_frame.valid && rx_en_q && keep;
    newent = '{fe: !rx_frame.stop1, pe: rx_frame.parity_err,
               data: rx_frame.data & mask};
  end

  // ****************************************************************
  // transmit path terms
  // ****************************************************************
  always_comb begin
    load = (tx_st_q == UAF_TX_IDLE) && txfull_q && tx_on_q;
    done = (tx_st_q == UAF_TX_SHIFT) && (baud_q == 16'h0000) && (left_q == 4'h1);
  end

  // ****************************************************************
  // register read mux, taken in the setup cycle
  // ****************************************************************
  always_comb begin
    rsel = 32'h0000_0000;
    case (paddr)
      `UAF_OFS_DATA: begin
        rsel[7:0] = (cnt_q != 2'h0) ? head.data[7:0] : 8'h00;
      end
      `UAF_OFS_STAT_A: begin
        rsel[`UAF_A_RX_DONE] = (cnt_q != 2'h0);
        rsel[`UAF_A_TX_DONE] = tx_done_q;
        rsel[`UAF_A_TX_FREE] = !txfull_q;
        rsel[`UAF_A_FE]   = (cnt_q != 2'h0) && head.fe;
        rsel[`UAF_A_DOR]  = dor_q;
        rsel[`UAF_A_PE]   = (cnt_q != 2'h0) && head.pe;
        rsel[`UAF_A_U2X]  = u2x_q;
        rsel[`UAF_A_FILT] = filt_q;
      end
      `UAF_OFS_CTRL_B: begin
        rsel[`UAF_B_RXEN]  = rx_en_q;
        rsel[`UAF_B_TXEN]  = tx_en_q;
        rsel[`UAF_B_SIZE2] = size_q[2];
        rsel[`UAF_B_RX9]   = (cnt_q != 2'h0) && head.data[8];
        rsel[`UAF_B_TX9]   = tx9_q;
      end
      `UAF_OFS_CTRL_C: begin
        rsel[`UAF_C_STOP]                   = stop2_q;
        rsel[`UAF_C_SIZE_HI:`UAF_C_SIZE_LO] = size_q[1:0];
      end
      default: rsel = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // next-state logic; one group because the fifo, flags and shifter
  // all react to the same bus access in the same cycle
  // ****************************************************************
  always_comb begin
    filt_d  = filt_q;
    u2x_d   = u2x_q;
    rx_en_d = rx_en_q;
    tx_en_d = tx_en_q;
    tx9_d   = tx9_q;
    stop2_d = stop2_q;
    size_d  = size_q;
    tx_done_d = tx_done_q;
    dor_d   = dor_q;
    ent_d   = ent_q;
    cnt_n   = cnt_q;
    txbuf_d = txbuf_q;
    txfull_d = txfull_q;
    tx_st_d = tx_st_q;
    sh_d    = sh_q;
    left_d  = left_q;
    baud_d  = baud_q;
    rdata_d = (psel && !penable) ? rsel : rdata_q;

    // control writes; filter mode is a plain bit, the transmitter never looks at it
    if (wr && paddr == `UAF_OFS_STAT_A) begin
      filt_d = pwdata[`UAF_A_FILT];
      u2x_d  = pwdata[`UAF_A_U2X];
      if (pwdata[`UAF_A_TX_DONE]) begin
        tx_done_d = 1'b0;
      end
    end
    if (wr && paddr == `UAF_OFS_CTRL_B) begin
      rx_en_d   = pwdata[`UAF_B_RXEN];
      tx_en_d   = pwdata[`UAF_B_TXEN];
      size_d[2] = pwdata[`UAF_B_SIZE2];
      tx9_d     = pwdata[`UAF_B_TX9];
    end
    if (wr && paddr == `UAF_OFS_CTRL_C) begin
      stop2_d     = pwdata[`UAF_C_STOP];
      size_d[1:0] = pwdata[`UAF_C_SIZE_HI:`UAF_C_SIZE_LO];
    end

    // each read of the data location advances the fifo and ends the overrun report
    if (rd_data && cnt_q != 2'h0) begin
      ent_d[0] = ent_q[1];
      cnt_n    = cnt_q - 2'h1;
      dor_d    = 1'b0;
    end
    // a new frame lands behind the pop; a full fifo drops it and flags overrun
    if (push) begin
      if (cnt_n != 2'h2) begin
        ent_d[cnt_n[0]] = newent;
        cnt_n           = cnt_n + 2'h1;
      end else begin
        dor_d = 1'b1;
      end
    end
    // a disabled receiver holds nothing
    if (!rx_en_q) begin
      cnt_n = 2'h0;
      dor_d = 1'b0;
    end
    cnt_d = cnt_n;

    // transmit buffer: writes only land while it is empty
    if (wr_data && !txfull_q) begin
      txbuf_d  = {tx9_q, pwdata[7:0]} & mask;
      txfull_d = 1'b1;
    end

    // shifter: start bit, data lsb first, then stop bits from the ones fill
    case (tx_st_q)
      UAF_TX_IDLE: begin
        if (load) begin
          sh_d     = {3'b111, txbuf_q | ~mask, 1'b0};
          left_d   = 4'(size_bits(size_q) + (stop2_q ? 4'h3 : 4'h2));
          baud_d   = 16'(BIT_CYCLES - 1);
          txfull_d = 1'b0;
          tx_st_d  = UAF_TX_SHIFT;
        end
      end
      UAF_TX_SHIFT: begin
        if (baud_q != 16'h0000) begin
          baud_d = baud_q - 16'h0001;
        end else begin
          sh_d   = {1'b1, sh_q[12:1]};
          left_d = left_q - 4'h1;
          baud_d = 16'(BIT_CYCLES - 1);
          if (left_q == 4'h1) begin
            tx_st_d = UAF_TX_IDLE;
          end
        end
      end
      default: tx_st_d = UAF_TX_IDLE;
    endcase

    // transmit complete: set wins over a clearing write in the same cycle
    if (done && !txfull_d) begin
      tx_done_d = 1'b1;
    end

    // disabling only takes hold once nothing is pending or shifting
    tx_on_d = tx_en_q || (tx_on_q && (txfull_q || tx_st_q == UAF_TX_SHIFT));
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q   <= 1'b0;
      u2x_q    <= 1'b0;
      rx_en_q  <= 1'b0;
      tx_en_q  <= 1'b0;
      tx9_q    <= 1'b0;
      stop2_q  <= 1'b0;
      size_q   <= {1'b0, `UAF_RST_SIZE10};
      tx_done_q <= 1'b0;
      dor_q    <= 1'b0;
      ent_q[0] <= '0;
      ent_q[1] <= '0;
      cnt_q    <= 2'h0;
      txbuf_q  <= 9'h000;
      txfull_q <= 1'b0;
      tx_on_q  <= 1'b0;
      tx_st_q  <= UAF_TX_IDLE;
      sh_q     <= 13'h1FFF;
      left_q   <= 4'h0;
      baud_q   <= 16'h0000;
      rdata_q  <= 32'h0000_0000;
    end else begin
      filt_q   <= filt_d;
      u2x_q    <= u2x_d;
      rx_en_q  <= rx_en_d;
      tx_en_q  <= tx_en_d;
      tx9_q    <= tx9_d;
      stop2_q  <= stop2_d;
      size_q   <= size_d;
      tx_done_q <= tx_done_d;
      dor_q    <= dor_d;
      ent_q    <= ent_d;
      cnt_q    <= cnt_d;
      txbuf_q  <= txbuf_d;
      txfull_q <= txfull_d;
      tx_on_q  <= tx_on_d;
      tx_st_q  <= tx_st_d;
      sh_q     <= sh_d;
      left_q   <= left_d;
      baud_q   <= baud_d;
      rdata_q  <= rdata_d;
    end
  end

  // outputs; idle line is high, the pin is driven only while the transmitter owns it
  assign txd       = (tx_st_q == UAF_TX_SHIFT) ? sh_q[0] : 1'b1;
  assign txd_oe    = tx_on_q;
  assign rx_enable = rx_en_q;
  assign char_size = size_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_filter_drop: assert property (@(posedge pclk) disable iff (!presetn)
    rx_frame.valid && rx_en_q && filt_q && !ftype && !rd_data |=> cnt_q == $past(cnt_q) && dor_q == $past(dor_q))
    else $error("filtered data frame changed the receive fifo");
  chk_addr_store: assert property (@(posedge pclk) disable iff (!presetn)
    rx_frame.valid && rx_en_q && ftype && cnt_q == 2'h0 |=>
      cnt_q == 2'h1 && (size_q != `UAF_SIZE_NINE || ent_q[0].data[8]))
    else $error("address frame not stored");
  chk_nine_type: assert property (@(posedge pclk) disable iff (!presetn)
    rx_frame.valid && rx_en_q && filt_q && size_q == `UAF_SIZE_NINE && !rx_frame.data[8] && !rd_data
      |=> $stable(cnt_q))
    else $error("ninth bit zero frame accepted in filter mode");
  chk_fifo_pop: assert property (@(posedge pclk) disable iff (!presetn)
    rd_data && cnt_q == 2'h2 && !rx_frame.valid && rx_en_q |=> cnt_q == 2'h1)
    else $error("data read did not advance the fifo");
  chk_rx_flush: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_en_q |=> cnt_q == 2'h0 && !dor_q)
    else $error("disabled receiver kept data");
  chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    push && cnt_q == 2'h0 && size_q == 3'h0 |=> ent_q[0].data[8:5] == 4'h0)
    else $error("unused upper bits stored");
  chk_tx_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    wr_data && txfull_q |=> txbuf_q == $past(txbuf_q))
    else $error("write to full transmit buffer changed it");
  chk_tx_load: assert property (@(posedge pclk) disable iff (!presetn)
    load |=> tx_st_q == UAF_TX_SHIFT && !txfull_q && !txd ##1 !txd)
    else $error("buffered character not moved into shifter");
  chk_tx_complete: assert property (@(posedge pclk) disable iff (!presetn)
    done && !txfull_q |=> tx_done_q && tx_st_q == UAF_TX_IDLE)
    else $error("transmit complete not raised");

endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the address-filtering serial port
`timescale 1ns/1ps
`include "uaf_defs.svh"

module tb_top import uaf_pkg::*; ;
  localparam int         BITC = 2;
  localparam logic [7:0] OD   = `UAF_OFS_DATA;
  localparam logic [7:0] OA   = `UAF_OFS_STAT_A;
  localparam logic [7:0] OB   = `UAF_OFS_CTRL_B;
  localparam logic [7:0] OC   = `UAF_OFS_CTRL_C;

  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [7:0]    paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  uaf_rx_frame_s rx_frame;
  logic          rx_enable;
  uaf_size_t     char_size;
  logic          txd;
  logic          txd_oe;
  int            num_errors;
  int            comparisons;

  uaf_top #(.BIT_CYCLES(BITC)) uaf_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame(rx_frame), .rx_enable(rx_enable), .char_size(char_size), .txd(txd), .txd_oe(txd_oe)
  );

  uaf_peer #(.BIT_CYCLES(BITC)) uaf_peer_inst (.pclk(pclk), .txd(txd), .rx_frame(rx_frame));

  // ****************
  // reporting and bus tasks
  // ****************
  task automatic close_out();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, entered and left just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, '0, r, e);
    chk(what, exp, r);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic sc_reset();
    logic [31:0] r;
    logic        e;
    rd(OA, 32'h0000_0020, "status a");
    rd(OB, 32'h0000_0000, "ctrl b");
    rd(OC, 32'h0000_0006, "ctrl c");
    rd(OD, 32'h0000_0000, "data");
    chk("char size", 32'h0000_0003, {29'b0, char_size});
    chk("idle pin", 32'h0000_0001, {30'b0, txd_oe, txd});
    // unmapped place refuses with an error and reads zero
    apb(1'b0, 8'h10, '0, r, e);
    chk("unmapped", 32'h0000_0001, {31'b0, e});
    chk("unmapped data", 32'h0000_0000, r);
  endtask

  task automatic sc_filter();
    wr(OB, 32'h0000_0014);
    chk("char size", 32'h0000_0007, {29'b0, char_size});
    wr(OA, 32'h0000_0001);
    uaf_peer_inst.send(9'h0C3, 1'b1);
    repeat (2) @(posedge pclk);
    rd(OA, 32'h0000_0021, "status a");
    uaf_peer_inst.send(9'h1A5, 1'b1);
    rd(OA, 32'h0000_00A1, "status a");
    rd(OB, 32'h0000_0016, "ctrl b");
    rd(OD, 32'h0000_00A5, "data");
    wr(OA, 32'h0000_0000);
    uaf_peer_inst.send(9'h03C, 1'b1);
    rd(OB, 32'h0000_0014, "ctrl b");
    rd(OD, 32'h0000_003C, "data");
    rd(OA, 32'h0000_0020, "status a");
    wr(OA, 32'h0000_0001);
  endtask

  task automatic sc_stop();
    wr(OB, 32'h0000_0010);
    uaf_peer_inst.send(9'h055, 1'b0);
    repeat (2) @(posedge pclk);
    rd(OA, 32'h0000_0021, "status a");
    uaf_peer_inst.send(9'h155, 1'b1);
    rd(OA, 32'h0000_00A1, "status a");
    rd(OD, 32'h0000_0055, "data");
  endtask

  task automatic sc_fifo();
    wr(OC, 32'h0000_0000);
    wr(OA, 32'h0000_0000);
    uaf_peer_inst.send(9'h1FF, 1'b1);
    uaf_peer_inst.send(9'h1E3, 1'b1);
    uaf_peer_inst.send(9'h0AA, 1'b1);
    rd(OA, 32'h0000_00A8, "status a");
    rd(OD, 32'h0000_001F, "data");
    rd(OD, 32'h0000_0003, "data");
    rd(OA, 32'h0000_0020, "status a");
    // a disable with one entry pending must flush it
    uaf_peer_inst.send(9'h011, 1'b1);
    wr(OB, 32'h0000_0000);
    chk("rx enable", 32'h0000_0000, {31'b0, rx_enable});
    wr(OB, 32'h0000_0010);
    rd(OA, 32'h0000_0020, "status a");
  endtask

  task automatic sc_tx();
    logic [8:0] v;
    logic       ok;
    wr(OC, 32'h0000_0006);
    wr(OA, 32'h0000_0001);
    wr(OB, 32'h0000_000D);
    fork
      begin
        wr(OD, 32'h1234_56A5);
        wr(OD, 32'h0000_003C);
        wr(OD, 32'h0000_00FF);
      end
      begin
        uaf_peer_inst.grab(9, v, ok);
        chk("tx frame", {22'b0, 1'b1, 9'h1A5}, {22'b0, ok, v});
        uaf_peer_inst.grab(9, v, ok);
        chk("tx frame", {22'b0, 1'b1, 9'h13C}, {22'b0, ok, v});
        uaf_peer_inst.grab(9, v, ok);
        chk("tx frame", 32'h0000_0000, {22'b0, ok, v});
      end
    join
    rd(OA, 32'h0000_0061, "status a");
    wr(OA, 32'h0000_0043);
    rd(OA, 32'h0000_0023, "status a");
    // five-bit frame: upper written bits must not reach the pin
    wr(OC, 32'h0000_0008);
    wr(OB, 32'h0000_0008);
    fork
      wr(OD, 32'h0000_00D5);
      uaf_peer_inst.grab(5, v, ok);
    join
    chk("tx frame", {22'b0, 1'b1, 9'h015}, {22'b0, ok, v});
  endtask

  // ****************
  // clock and main sequence
  // ****************
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    num_errors = 0;
    comparisons = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sc_reset();
    sc_filter();
    sc_stop();
    sc_fifo();
    sc_tx();
    close_out();
  end
endmodule

// ==== test/uaf_peer.sv ====
// bus peer model: hands frames to the receiver and samples the transmit pin
`timescale 1ns/1ps

module uaf_peer import uaf_pkg::*; #(
  parameter int BIT_CYCLES = 2
) (
  // clock
  input  wire logic     pclk,
  // serial side
  input  wire logic     txd,
  output uaf_rx_frame_s rx_frame
);
  initial rx_frame = '0;

  // ****************
  // frames toward the block
  // ****************
  // with 5 to 8 bit frames stop1 is the frame type, so the sender uses two stop bits
  // the ninth bit is one for an address frame and zero for a data frame
  task automatic send(input logic [8:0] d, input logic stop1);
    @(posedge pclk);
    rx_frame <= '{valid: 1'b1, data: d, stop1: stop1, parity_err: 1'b0};
    @(posedge pclk);
    // invert the released fields so stale data never passes for a frame
    rx_frame <= '{valid: 1'b0, data: ~d, stop1: ~stop1, parity_err: 1'b0};
  endtask

  // one frame from the pin; ok stays low when no frame starts in time or the stop bit is wrong
  task automatic grab(input int n, output logic [8:0] v, output logic ok);
    int i;
    v = '0;
    ok = 1'b0;
    for (i = 0; i < 40 * BIT_CYCLES && !ok; i++) begin
      @(posedge pclk);
      ok = (txd === 1'b0);
    end
    if (ok) begin
      for (i = 0; i <= n; i++) begin
        repeat (BIT_CYCLES) @(posedge pclk);
        if (i < n) begin
          v[i] = txd;
        end else begin
          ok = (txd === 1'b1);
        end
      end
    end
  endtask
endmodule
